// [srh_pkg.sv]
// Constants and carrier types for the static memory host controller.
// Assumes a single 10 MHz clock; all memory timings are met by whole cycles.
// How it works
// - Host keeps write strobe high whenever the address changes.
// - Host sets the address before or with select falling.
// - Host keeps output drive high during writes, so no data-in contention.
// - Host holds select low at least 7 or 8 ns before write end.
// - Host holds address valid at least 7 or 8 ns before write end.
// - Host sets data-in 5 or 6 ns before write end, holds after.
// - Host makes each write interval last at least 7 or 8 ns.
// - Host allows at least 0 ns from address change to write start.
// - Host allows at least 0 ns from write end to next address change.
package srh_pkg;
	localparam int ADDR_W              = 22;
	localparam int CLK_PERIOD_NS       = 100;
	// Slow grade figures, which also cover the fast grade
	localparam int ADDRESS_TO_DATA_MAX_NS     = 12;
	localparam int DRIVE_TO_DATA_MAX_NS       = 6;
	localparam int DESELECT_FLOAT_MAX_NS      = 6;
	localparam int WRITE_PULSE_MIN_NS         = 8;
	localparam int DATA_BEFORE_WRITE_END_NS   = 6;
	localparam int ADDRESS_SETUP_MIN_NS       = 0;
	localparam int WRITE_RECOVERY_MIN_NS      = 0;
	// Least times round up, at least one cycle
	localparam int READ_WAIT_CYC  = (ADDRESS_TO_DATA_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_LOW_CYC  = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_WAIT_CYC = (DESELECT_FLOAT_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	typedef enum logic [2:0] {
		SRH_IDLE   = 3'b000,
		SRH_SETUP  = 3'b001,
		SRH_STROBE = 3'b011,
		SRH_WAIT   = 3'b010,
		SRH_DONE   = 3'b110
	} srh_state_e;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic              data;
	} srh_req_s;
endpackage : srh_pkg

// [srh_host.sv]
// Host controller for a clockless one-bit-wide static memory.
// Assumes the memory pins are wired straight across; data-out is sampled synchronously.
`timescale 1ns/1ns
module srh_host #(
	parameter int READ_CYC  = srh_pkg::READ_WAIT_CYC,
	parameter int WRITE_CYC = srh_pkg::WRITE_LOW_CYC,
	parameter int FLOAT_CYC = srh_pkg::FLOAT_WAIT_CYC
) (
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	input  wire logic                      REQ_VALID,
	input  wire srh_pkg::srh_req_s         REQ,
	output logic                           REQ_READY,
	output logic                           RD_VALID,
	output logic                           RD_DATA,
	output logic [srh_pkg::ADDR_W-1:0]     MEM_ADDR,
	output logic                           MEM_SEL_N,
	output logic                           MEM_DRIVE_N,
	output logic                           MEM_WSTB_N,
	output logic                           MEM_DIN,
	input  wire logic                      MEM_DOUT
);
	import srh_pkg::*;

	srh_state_e             state_ff;
	srh_state_e             nxt_state;
	logic                   wr_ff;
	logic [3:0]             cnt_ff;
	logic [ADDR_W-1:0]      addr_ff;
	logic                   din_ff;
	logic                   sel_n_ff;
	logic                   drv_n_ff;
	logic                   wstb_n_ff;
	logic                   rdv_ff;
	logic                   rdd_ff;

	// Sequencer: setup cycle, strobe cycles, float cycles, done
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SRH_IDLE:   if (REQ_VALID) nxt_state = SRH_SETUP;
			SRH_SETUP:  nxt_state = SRH_STROBE;
			SRH_STROBE: if (cnt_ff == CNT_ZERO) nxt_state = SRH_WAIT;
			SRH_WAIT:   if (cnt_ff == CNT_ZERO) nxt_state = SRH_DONE;
			SRH_DONE:   nxt_state = SRH_IDLE;
			default:    nxt_state = SRH_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= SRH_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Cycle counter for strobe width and output float
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_ff <= CNT_ZERO;
		end else if (state_ff == SRH_SETUP) begin
			cnt_ff <= wr_ff ? 4'(WRITE_CYC - 1) : 4'(READ_CYC - 1);
		end else if (state_ff == SRH_STROBE && cnt_ff == CNT_ZERO) begin
			cnt_ff <= 4'(FLOAT_CYC - 1);
		end else if (cnt_ff != CNT_ZERO) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end

	// Address and data latch only in idle, while all strobes are high
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_ff <= '0;
			din_ff  <= 1'b0;
			wr_ff   <= 1'b0;
		end else if (state_ff == SRH_IDLE && REQ_VALID) begin
			addr_ff <= REQ.addr;
			din_ff  <= REQ.data;
			wr_ff   <= REQ.write;
		end
	end

	// Select and strobes; write strobe falls after select and rises with it on the same edge
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sel_n_ff  <= 1'b1;
			drv_n_ff  <= 1'b1;
			wstb_n_ff <= 1'b1;
		end else begin
			sel_n_ff  <= !(nxt_state == SRH_SETUP || nxt_state == SRH_STROBE);
			drv_n_ff  <= !(nxt_state == SRH_STROBE && !wr_ff);
			wstb_n_ff <= !(nxt_state == SRH_STROBE && wr_ff);
		end
	end

	// Read data sampled at the last strobe cycle, before select rises
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdv_ff <= 1'b0;
			rdd_ff <= 1'b0;
		end else begin
			rdv_ff <= 1'b0;
			if (state_ff == SRH_STROBE && cnt_ff == CNT_ZERO && !wr_ff) begin
				rdv_ff <= 1'b1;
				rdd_ff <= MEM_DOUT;
			end
		end
	end

	// Ready only in idle
	logic rdy_ff;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdy_ff <= 1'b0;
		end else begin
			rdy_ff <= (nxt_state == SRH_IDLE) && !(state_ff == SRH_IDLE && REQ_VALID);
		end
	end

	assign REQ_READY   = rdy_ff;
	assign RD_VALID    = rdv_ff;
	assign RD_DATA     = rdd_ff;
	assign MEM_ADDR    = addr_ff;
	assign MEM_DIN     = din_ff;
	assign MEM_SEL_N   = sel_n_ff;
	assign MEM_DRIVE_N = drv_n_ff;
	assign MEM_WSTB_N  = wstb_n_ff;
endmodule : srh_host

// [srh_host_sva.sv]
// Checker on the memory-side pins of the static memory host.
// Assumes the slow-grade figures all fit in one 100 ns cycle.
`timescale 1ns/1ns
module srh_host_sva (
	input wire logic                      CLK,
	input wire logic                      RSTN,
	input wire logic [srh_pkg::ADDR_W-1:0] MEM_ADDR,
	input wire logic                      MEM_SEL_N,
	input wire logic                      MEM_DRIVE_N,
	input wire logic                      MEM_WSTB_N,
	input wire logic                      MEM_DIN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Write start and end of a one-cycle strobe
	sequence s_wstart; !MEM_SEL_N && !MEM_WSTB_N; endsequence
	sequence s_wend; MEM_SEL_N && MEM_WSTB_N; endsequence
	a_addr_held_strobe: assert property (!MEM_WSTB_N |-> $stable(MEM_ADDR)) else $error("address moved in write");
	a_addr_held_select: assert property (!MEM_SEL_N && !$fell(MEM_SEL_N) |-> $stable(MEM_ADDR)) else $error("address moved");
	a_drive_off_write: assert property (!MEM_WSTB_N |-> MEM_DRIVE_N) else $error("drive low in write");
	a_sel_before_end: assert property ($fell(MEM_WSTB_N) |-> $past(!MEM_SEL_N)) else $error("select late");
	a_write_pulse_len: assert property ($fell(MEM_WSTB_N) |-> s_wstart ##1 s_wend) else $error("write pulse wrong");
	a_data_held_write: assert property (!MEM_WSTB_N |-> $stable(MEM_DIN) ##1 $stable(MEM_DIN)) else $error("data moved");
	a_addr_setup_ok: assert property ($fell(MEM_WSTB_N) |-> $stable(MEM_ADDR)) else $error("address setup");
	a_addr_recovery_ok: assert property ($rose(MEM_WSTB_N) |-> $stable(MEM_ADDR)) else $error("address recovery");
endmodule : srh_host_sva

// [srh_mem_model.sv]
// Behavioural one-bit static memory, no clock.
// Assumes pins wired straight to the host; unknown cells read as 0.
`timescale 1ns/1ns
module srh_mem_model #(
	parameter int DLY = 6
) (
	input wire logic [srh_pkg::ADDR_W-1:0] addr,
	input wire logic                      sel_n,
	input wire logic                      drive_n,
	input wire logic                      wstb_n,
	input wire logic                      din,
	output wire logic                     dout
);
	logic m [logic [srh_pkg::ADDR_W-1:0]];
	logic q = 1'b0;
	// Store only in the select and strobe overlap
	always @* if (!sel_n && !wstb_n) m[addr] = din;
	// Read cell only while output is enabled
	always @* if (!sel_n && !drive_n && wstb_n) q = m.exists(addr) ? m[addr] : 1'b0;
	// Floated line shows the inverse of the last bit
	assign #DLY dout = (!sel_n && !drive_n && wstb_n) ? q : ~q;
endmodule : srh_mem_model

// [testbench.sv]
// Self-checking bench for the static memory host with a memory model.
// Assumes default cycle counts; random ops from a 16-bit shift register.
`timescale 1ns/1ns
module testbench;
	import srh_pkg::*;
	logic clk = 0, rstn = 0, rv = 0, rdy, rvld, rd, sel_n, drv_n, wstb_n, din, dout;
	srh_req_s req = '0;
	logic [ADDR_W-1:0] addr, a;
	logic ref_m [logic [ADDR_W-1:0]];
	logic [15:0] lf = 16'hfbff;
	int num_errors = 0, checked = 0, cyc = 0;
	always #50 clk = ~clk;
	srh_host srh_host_inst (.CLK(clk), .RSTN(rstn), .REQ_VALID(rv), .REQ(req), .REQ_READY(rdy), .RD_VALID(rvld),
		.RD_DATA(rd), .MEM_ADDR(addr), .MEM_SEL_N(sel_n), .MEM_DRIVE_N(drv_n), .MEM_WSTB_N(wstb_n),
		.MEM_DIN(din), .MEM_DOUT(dout));
	srh_mem_model srh_mem_model_inst (.addr(addr), .sel_n(sel_n), .drive_n(drv_n), .wstb_n(wstb_n),
		.din(din), .dout(dout));
	// Count and report one mismatch
	task miss(string m);
		num_errors++;
		$display("MISMATCH %0t %s", $time, m);
	endtask : miss
	// Read bit against the reference memory
	task chk(logic e, logic g);
		checked++;
		if (g !== e) miss("read bit");
	endtask : chk
	// Memory pin level against its required idle level
	task chk_flag(logic e, logic g);
		checked++;
		if (g !== e) miss("pin level in reset");
	endtask : chk_flag
	// Next value of the 16-bit shift register
	function automatic logic [15:0] lfsr_next(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	// Hold reset three cycles; strobes must sit high meanwhile
	task do_reset;
		rstn = 0;
		repeat (3) @(negedge clk);
		chk_flag(1'b1, sel_n);
		chk_flag(1'b1, wstb_n);
		chk_flag(1'b1, drv_n);
		rstn = 1;
	endtask : do_reset
	task final_report;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	// One request, then the read answer if any
	task xfer(logic w, logic [ADDR_W-1:0] ad, logic d);
		int n;
		n = 0;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 20) begin @(negedge clk); n++; end
		if (rdy !== 1'b1) miss("ready timeout");
		rv = 1;
		req = '{write: w, addr: ad, data: d};
		@(negedge clk);
		rv = 0;
		if (w) ref_m[ad] = d;
		else begin
			n = 0;
			while (rvld !== 1'b1 && n < 10) begin @(negedge clk); n++; end
			if (rvld !== 1'b1) miss("read answer timeout");
			chk(ref_m.exists(ad) ? ref_m[ad] : 1'b0, rd);
		end
	endtask : xfer
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin num_errors++; final_report; end
	end
	initial begin
		do_reset;
		for (int i = 0; i < 80; i++) begin
			// Second reset in mid-run, once the last transfer has drained
			if (i == 40) begin
				repeat (5) @(negedge clk);
				do_reset;
			end
			lf = lfsr_next(lf);
			a = lf[0] ? {ADDR_W{lf[1]}} : ADDR_W'(lf[6:2]);
			xfer(lf[8], a, lf[9]);
		end
		final_report;
	end
endmodule : testbench
bind srh_host srh_host_sva srh_host_sva_inst (.CLK(CLK), .RSTN(RSTN), .MEM_ADDR(MEM_ADDR), .MEM_SEL_N(MEM_SEL_N),
	.MEM_DRIVE_N(MEM_DRIVE_N), .MEM_WSTB_N(MEM_WSTB_N), .MEM_DIN(MEM_DIN));
